// ==== include/irq_ack_map.svh ====
// Constants for the interrupt acknowledge sequencer.
`ifndef IRQ_ACK_MAP_SVH
`define IRQ_ACK_MAP_SVH
`define IRQ_LINES          8
`define VECTOR_W           8
`define CASCADE_W          3
`define VECTOR_BASE_RESET  8'h40
`define BUS_LINE_MASK_RST  8'h40
`endif

// ==== include/irq_ack_pkg.sv ====
// Types shared by the interrupt acknowledge sequencer.
package irq_ack_pkg;
	typedef enum logic [1:0] {
		ACK_IDLE,
		ACK_FIRST,
		ACK_BETWEEN,
		ACK_SECOND
	} ack_state_t;
endpackage

// ==== verif/cpu_ack_model.sv ====
// Processor side model that issues the two acknowledge strobes.
`timescale 1ns/10ps
module cpu_ack_model (
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic       irq,
	input  wire logic [3:0] hold,
	output logic            strobe_n
);
	initial begin
		strobe_n = 1'b1;
		forever begin
			@(posedge clk);
			// A request is only taken while enabled, so it stays pending.
			if (go && irq) begin
				for (int k = 0; k < 4; k++) begin
					strobe_n <= k[0];
					repeat (hold) @(posedge clk);
				end
			end
		end
	end
endmodule

// ==== verif/vectored_interrupt_ack_sequencer_asserts.sv ====
// Port assertions for the acknowledge sequencer.
`timescale 1ns/10ps
module irq_ack_seq_checker (
	input wire logic       REF_CLK,
	input wire logic       RESETN,
	input wire logic       CASCADE_ENABLE_STATUS,
	input wire logic       CPU_IRQ_REQUEST,
	input wire logic       CPU_READY,
	input wire logic       FIRST_ACK_READY_N,
	input wire logic       BUS_LOCK_N,
	input wire logic       PIC_DATA_ENABLE_N,
	input wire logic       LOCAL_ACK_BUFFER_EN_N,
	input wire logic       BUS_ACK_DRIVER_EN_N,
	input wire logic       SYSBUS_DATA_RECEIVE,
	input wire logic [2:0] CASCADE_CODE,
	input wire logic [2:0] CPU_ADDR_CASCADE_BITS
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);
	ready_first_a: assert property (
		$fell(FIRST_ACK_READY_N) |-> CPU_READY && !CPU_IRQ_REQUEST)
		else $error("no ready at first ack");
	lock_hold_a: assert property (
		!FIRST_ACK_READY_N |-> !BUS_LOCK_N) else $error("lock lost");
	ack_clear_a: assert property (
		$rose(FIRST_ACK_READY_N) |-> !BUS_LOCK_N)
		else $error("first ack cleared outside sequence");
	local_data_a: assert property (
		!LOCAL_ACK_BUFFER_EN_N |-> !PIC_DATA_ENABLE_N && CPU_READY)
		else $error("local enable without ready");
	bus_recv_a: assert property (
		!BUS_ACK_DRIVER_EN_N |-> SYSBUS_DATA_RECEIVE && !PIC_DATA_ENABLE_N)
		else $error("bus driver not receiving");
	bus_excl_a: assert property (
		!BUS_ACK_DRIVER_EN_N |-> LOCAL_ACK_BUFFER_EN_N)
		else $error("both enables low");
	cas_route_a: assert property (
		CPU_ADDR_CASCADE_BITS ==
		(CASCADE_ENABLE_STATUS ? CASCADE_CODE : 3'h0))
		else $error("cascade routing wrong");
	code_freeze_a: assert property (
		!$past(BUS_ACK_DRIVER_EN_N, 2) && !BUS_ACK_DRIVER_EN_N
		|-> $stable(CASCADE_CODE)) else $error("cascade code moved");
	reset_clear_a: assert property (disable iff (1'b0)
		!RESETN |=> FIRST_ACK_READY_N && BUS_LOCK_N)
		else $error("flop not cleared by reset");
endmodule
bind vectored_interrupt_ack_sequencer irq_ack_seq_checker chk_i (.*);

// ==== verif/vectored_interrupt_ack_sequencer_tb.sv ====
// Self-checking bench for the acknowledge sequencer.
`timescale 1ns/10ps
module vectored_interrupt_ack_sequencer_tb;
	logic       clk = 0, rstn = 0, go = 0, ale = 0, done = 0, ce = 0;
	logic       stb_n, req, rdy, fa_n, lk_n, pd_n, la_n, ba_n, rcv;
	logic [7:0] lines = 8'h00, vec;
	logic [3:0] hold = 4'h3;
	logic [2:0] cc, ca, sa;
	logic       ins;
	int         num_errors = 0, checked = 0, i;
	always #12.5 clk = ~clk;
	vectored_interrupt_ack_sequencer DUT (.REF_CLK(clk), .RESETN(rstn),
		.IRQ_LINES(lines), .BUS_CASCADED_LINES(8'h40),
		.VECTOR_BASE(8'hA0), .IRQ_ACK_STROBE_N(stb_n),
		.CASCADE_ENABLE_STATUS(ce), .ALE(ale), .IRQ_DONE(done),
		.CPU_IRQ_REQUEST(req), .CPU_READY(rdy), .FIRST_ACK_READY_N(fa_n),
		.BUS_LOCK_N(lk_n), .CPU_DATA_OUT(vec), .PIC_DATA_ENABLE_N(pd_n),
		.LOCAL_ACK_BUFFER_EN_N(la_n), .BUS_ACK_DRIVER_EN_N(ba_n),
		.SYSBUS_DATA_RECEIVE(rcv), .CASCADE_CODE(cc),
		.CPU_ADDR_CASCADE_BITS(ca), .SYSBUS_ADDR_CASCADE_BITS_N(sa),
		.IN_SERVICE(ins));
	cpu_ack_model cpu (.clk(clk), .go(go), .irq(req), .hold(hold),
		.strobe_n(stb_n));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task conclude;
		if (num_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task serve(input logic [2:0] idx, input logic bus);
		for (i = 0; i < 30 && req !== 1; i++) @(negedge clk);
		chk({7'h0, req}, 8'h1);
		@(posedge clk) go <= 1;
		for (i = 0; i < 30 && fa_n !== 0; i++) @(negedge clk);
		chk({4'h0, fa_n, rdy, lk_n, req}, 8'h4);
		if (bus) begin
			@(negedge clk);
			chk({ba_n, rcv, cc, ca}, {2'b01, idx, idx});
			@(posedge clk) ale <= 1;
			repeat (3) @(posedge clk);
			ale <= 0;
			repeat (6) @(negedge clk);
			chk({5'h0, sa}, {5'h0, ~idx});
		end
		@(posedge clk) go <= 0;
		for (i = 0; i < 60 && fa_n !== 1; i++) @(negedge clk);
		chk({6'h0, fa_n, lk_n}, 8'h2);
		if (bus)
			chk({6'h0, ba_n, rcv}, 8'h1);
		if (!bus) begin
			for (i = 0; i < 20 && la_n !== 0; i++) @(negedge clk);
			chk({5'h0, la_n, pd_n, rdy}, 8'h1);
			chk(vec, 8'hA0 | {5'h0, idx});
		end
		for (i = 0; i < 40 && lk_n !== 1; i++) @(negedge clk);
		chk({4'h0, lk_n, ba_n, la_n, ins}, 8'hF);
	endtask
	task eoi;
		@(posedge clk) done <= 1;
		@(posedge clk) done <= 0;
		@(negedge clk) chk({7'h0, ins}, 8'h0);
		@(posedge clk);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1;
		repeat (4) @(posedge clk);
		lines <= 8'h20;
		serve(3'd5, 0);
		// Line 7 ranks below line 5, which is still in service.
		@(posedge clk) lines <= 8'hA0;
		repeat (20) @(negedge clk);
		chk({7'h0, req}, 8'h0);
		eoi;
		hold <= 4'h6;
		serve(3'd7, 0);
		eoi;
		ce <= 1;
		lines <= 8'hE0;
		serve(3'd6, 1);
		conclude;
	end
	initial begin
		#50000;
		num_errors++;
		conclude;
	end
endmodule

// ==== verilog/vectored_interrupt_ack_sequencer.sv ====
// Interrupt acknowledge sequencer with local and bus vectored sources.
`timescale 1ns/10ps
`include "irq_ack_map.svh"
// Overview of operation
// - A line edge with no higher line in service raises the CPU request.
// - The bus lock is held low from the first strobe until the second ends.
// - The first strobe freezes the priority choice for the whole sequence.
// - The first strobe sets the first-ack flop whose low output makes ready.
// - The second strobe clears the first-ack flop.
// - The second strobe puts a local 8-bit vector out and drops data enable.
// - The local data enable opens the local buffer and also makes ready.
// - A bus line's first strobe asserts bus data enable and its 3-bit code.
// - With cascade enable the code reaches the system address as ALE falls.
// - The bus data enable turns the system data driver toward the CPU.
// - Names ending in _n are active low.
module vectored_interrupt_ack_sequencer
	import irq_ack_pkg::*;
#(
	parameter int LINES = `IRQ_LINES
) (
	input  wire logic                    REF_CLK,
	input  wire logic                    RESETN,
	input  wire logic [LINES-1:0]        IRQ_LINES,
	input  wire logic [LINES-1:0]        BUS_CASCADED_LINES,
	input  wire logic [`VECTOR_W-1:0]    VECTOR_BASE,
	input  wire logic                    IRQ_ACK_STROBE_N,
	input  wire logic                    CASCADE_ENABLE_STATUS,
	input  wire logic                    ALE,
	input  wire logic                    IRQ_DONE,
	output logic                         CPU_IRQ_REQUEST,
	output logic                         CPU_READY,
	output logic                         FIRST_ACK_READY_N,
	output logic                         BUS_LOCK_N,
	output logic [`VECTOR_W-1:0]         CPU_DATA_OUT,
	output logic                         PIC_DATA_ENABLE_N,
	output logic                         LOCAL_ACK_BUFFER_EN_N,
	output logic                         BUS_ACK_DRIVER_EN_N,
	output logic                         SYSBUS_DATA_RECEIVE,
	output logic [`CASCADE_W-1:0]        CASCADE_CODE,
	output logic [`CASCADE_W-1:0]        CPU_ADDR_CASCADE_BITS,
	output logic [`CASCADE_W-1:0]        SYSBUS_ADDR_CASCADE_BITS_N,
	output logic                         IN_SERVICE
);

	if (LINES != 8) begin : g_lines_check
		$error("Cascade code is three bits: LINES must be 8.");
	end

	// ----------------------------------------------------------------
	// Input synchronisers (three stages, change once stages 2/3 agree).
	// ----------------------------------------------------------------
	logic [LINES-1:0] irq_s1_ff, irq_s2_ff, irq_s3_ff, irq_ff, irq_prev_ff;
	logic [2:0]       ack_s_ff;
	logic             ack_n_ff;
	logic [2:0]       ale_s_ff;
	logic             ale_ff;

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			irq_s1_ff   <= '0;
			irq_s2_ff   <= '0;
			irq_s3_ff   <= '0;
			irq_ff      <= '0;
			irq_prev_ff <= '0;
		end else begin
			irq_s1_ff   <= IRQ_LINES;
			irq_s2_ff   <= irq_s1_ff;
			irq_s3_ff   <= irq_s2_ff;
			for (int i = 0; i < LINES; i++) begin
				if (irq_s2_ff[i] == irq_s3_ff[i])
					irq_ff[i] <= irq_s3_ff[i];
			end
			irq_prev_ff <= irq_ff;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			ack_s_ff <= 3'h7;
			ack_n_ff <= 1'b1;
			ale_s_ff <= 3'h0;
			ale_ff   <= 1'b0;
		end else begin
			ack_s_ff <= {ack_s_ff[1:0], IRQ_ACK_STROBE_N};
			if (ack_s_ff[1] == ack_s_ff[2])
				ack_n_ff <= ack_s_ff[2];
			ale_s_ff <= {ale_s_ff[1:0], ALE};
			if (ale_s_ff[1] == ale_s_ff[2])
				ale_ff <= ale_s_ff[2];
		end
	end

	logic ack_fall;
	logic ack_rise;
	logic ale_fall;
	logic ack_prev_ff;
	logic ale_prev_ff;

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			ack_prev_ff <= 1'b1;
			ale_prev_ff <= 1'b0;
		end else begin
			ack_prev_ff <= ack_n_ff;
			ale_prev_ff <= ale_ff;
		end
	end

	assign ack_fall = ack_prev_ff & ~ack_n_ff;
	assign ack_rise = ~ack_prev_ff & ack_n_ff;
	assign ale_fall = ale_prev_ff & ~ale_ff;

	// ----------------------------------------------------------------
	// Priority: line 0 is highest.
	// ----------------------------------------------------------------
	function automatic logic [2:0] first_set(input logic [LINES-1:0] v);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = LINES - 1; i >= 0; i--) begin
			if (v[i])
				idx = 3'(i);
		end
		return idx;
	endfunction

	logic [LINES-1:0] pending_ff;
	logic [LINES-1:0] isr_ff;
	logic [LINES-1:0] higher_busy;
	logic [LINES-1:0] eligible;

	always_comb begin
		higher_busy = '0;
		for (int i = 1; i < LINES; i++)
			higher_busy[i] = higher_busy[i-1] | isr_ff[i-1];
	end
	assign eligible = pending_ff & ~(higher_busy | isr_ff);

	ack_state_t       state_ff;
	logic [2:0]       sel_ff;
	logic             sel_bus_ff;

	// A new rising edge on a line stays pending until acknowledged, even
	// when it arrives on the cycle its acknowledge takes it.
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			pending_ff <= '0;
		end else begin
			for (int i = 0; i < LINES; i++) begin
				if (irq_ff[i] & ~irq_prev_ff[i])
					pending_ff[i] <= 1'b1;
				else if (state_ff == ACK_IDLE && ack_fall &&
				         first_set(eligible) == 3'(i) && |eligible)
					pending_ff[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			isr_ff <= '0;
		end else begin
			for (int i = 0; i < LINES; i++) begin
				if (state_ff == ACK_SECOND && ack_rise && sel_ff == 3'(i))
					isr_ff[i] <= 1'b1;
				else if (IRQ_DONE && first_set(isr_ff) == 3'(i))
					isr_ff[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			CPU_IRQ_REQUEST <= 1'b0;
		else
			// The request drops on the edge that sees the first strobe.
			CPU_IRQ_REQUEST <= |eligible && state_ff == ACK_IDLE &&
			    !ack_fall;
	end

	// ----------------------------------------------------------------
	// Acknowledge sequence; the CPU gives two strobes back to back.
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			state_ff   <= ACK_IDLE;
			sel_ff     <= 3'h0;
			sel_bus_ff <= 1'b0;
		end else begin
			unique case (state_ff)
				ACK_IDLE: begin
					if (ack_fall) begin
						state_ff   <= ACK_FIRST;
						sel_ff     <= first_set(eligible);
						sel_bus_ff <= |(BUS_CASCADED_LINES &
						    (LINES'(1) << first_set(eligible)));
					end
				end
				ACK_FIRST: begin
					if (ack_rise)
						state_ff <= ACK_BETWEEN;
				end
				ACK_BETWEEN: begin
					if (ack_fall)
						state_ff <= ACK_SECOND;
				end
				ACK_SECOND: begin
					if (ack_rise)
						state_ff <= ACK_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			FIRST_ACK_READY_N <= 1'b1;
		else if (state_ff == ACK_IDLE && ack_fall)
			FIRST_ACK_READY_N <= 1'b0;
		else if (state_ff == ACK_BETWEEN && ack_fall)
			FIRST_ACK_READY_N <= 1'b1;
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			BUS_LOCK_N <= 1'b1;
		else if (state_ff == ACK_IDLE && ack_fall)
			BUS_LOCK_N <= 1'b0;
		else if (state_ff == ACK_SECOND && ack_rise)
			BUS_LOCK_N <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Vector and cascade paths.
	// ----------------------------------------------------------------
	logic local_den;
	logic bus_den;
	// Enables drop on the edge that sees the last strobe rise, together
	// with the bus lock, so no data path outlives the locked sequence.
	assign local_den = state_ff == ACK_SECOND && !sel_bus_ff && !ack_rise;
	assign bus_den   = state_ff != ACK_IDLE && sel_bus_ff &&
	    !(state_ff == ACK_SECOND && ack_rise);

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			CPU_DATA_OUT          <= '0;
			PIC_DATA_ENABLE_N     <= 1'b1;
			LOCAL_ACK_BUFFER_EN_N <= 1'b1;
			BUS_ACK_DRIVER_EN_N   <= 1'b1;
			SYSBUS_DATA_RECEIVE   <= 1'b0;
		end else begin
			CPU_DATA_OUT <= local_den ?
			    (VECTOR_BASE | `VECTOR_W'(sel_ff)) : '0;
			PIC_DATA_ENABLE_N     <= ~(local_den | bus_den);
			LOCAL_ACK_BUFFER_EN_N <= ~local_den;
			BUS_ACK_DRIVER_EN_N   <= ~bus_den;
			SYSBUS_DATA_RECEIVE   <= bus_den;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			CASCADE_CODE <= '0;
		else
			CASCADE_CODE <= bus_den ? sel_ff : '0;
	end

	// The CPU address bits carry the code only while the gate is open.
	assign CPU_ADDR_CASCADE_BITS = CASCADE_ENABLE_STATUS ?
	    CASCADE_CODE : '0;

	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			SYSBUS_ADDR_CASCADE_BITS_N <= '1;
		else if (ale_fall)
			SYSBUS_ADDR_CASCADE_BITS_N <= ~CPU_ADDR_CASCADE_BITS;
	end

	// Ready comes from the first-ack flop or the local data enable.
	assign CPU_READY  = ~FIRST_ACK_READY_N | ~LOCAL_ACK_BUFFER_EN_N;
	assign IN_SERVICE = |isr_ff;

endmodule
